// File: common/udc_pkg.sv
// Purpose: Shared constants and types of the USB device control register
// Assumes: 20 MHz system clock, one register word
// Notes: Field positions follow the packed control struct
`default_nettype none

package udc_pkg;

	// Byte address of the control register
	localparam logic [31:0] CTRL_OFS = 32'h400a4000;
	// Width of the stored register image
	localparam int CTRL_W = 12;
	// Address value used before address state
	localparam logic [6:0] DEFAULT_ADDR = 7'h00;

	// System clock rate
	localparam int CLK_HZ = 20_000_000;
	// Least continuous suspend before an upstream resume
	localparam int SUSPEND_MIN_MS = 5;
	// Suspend time in cycles, exact at this rate
	localparam int SUSPEND_MIN_CYC = (CLK_HZ / 1000) * SUSPEND_MIN_MS;
	// Length of the upstream resume that we drive
	localparam int RESUME_US = 2000;
	// Resume length in cycles, rounded down
	localparam int RESUME_CYC = (CLK_HZ / 1_000_000) * RESUME_US;
	// Width of the hold timers, covers the counts above
	localparam int TMR_W = 17;

	// Control register image, bit 11 down to bit 0
	typedef struct packed
	{
		logic pulldown_disable;
		logic remote_wake_request;
		logic detach;
		logic controller_enable;
		logic address_state_enable;
		logic [6:0] function_address;
	} udc_ctrl_t;

	// Reset image: disabled, detached, default address
	localparam udc_ctrl_t CTRL_RESET = 12'h200;

	// Transceiver controls
	typedef struct packed
	{
		logic suspend_n;
		logic pullup_en;
		logic xcvr_en;
		logic pulldown_disable;
	} udc_xcvr_t;

	// Upstream resume sequencer states
	typedef enum logic {RS_IDLE, RS_DRIVE} udc_rs_t;

endpackage : udc_pkg

`default_nettype wire

// File: src/udc_hold_timer.sv
// Purpose: Reports that an input level has stood for a set number of cycles
// Assumes: run is synchronous to sys_clk
// Notes: Any low cycle on run restarts the count
`default_nettype none

module udc_hold_timer
	import udc_pkg::*;
#(
	parameter int N = 16
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Level to time
	input wire logic run,
	// High once run has stood N cycles
	output logic done
);

	// Saturating cycle count
	logic [TMR_W-1:0] cnt_q;

	// Count while run holds, restart on any gap
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			cnt_q <= '0;
		else if (!run)
			cnt_q <= '0;
		else if (cnt_q != TMR_W'(N))
			cnt_q <= cnt_q + TMR_W'(1);
	end

	// Saturation means the full time has passed
	assign done = run && (cnt_q == TMR_W'(N));

endmodule : udc_hold_timer

`default_nettype wire

// File: src/udc_addr_match.sv
// Purpose: Decides whether a token address belongs to this device
// Assumes: Token address arrives with a one-cycle valid
// Notes: Answer is registered, one cycle after the token
`default_nettype none

module udc_addr_match
	import udc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Current address setup
	input wire logic enabled,
	input wire logic addr_state,
	input wire logic [6:0] func_addr,
	// Token from the link
	input wire logic tok_valid,
	input wire logic [6:0] tok_addr,
	// Token accepted
	output logic tok_match
);

	// Address in force now
	logic [6:0] live_addr;

	// Default address until address state is entered
	assign live_addr = addr_state ? func_addr : DEFAULT_ADDR;

	// Register the decision; a disabled controller accepts nothing
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			tok_match <= 1'b0;
		else
			tok_match <= tok_valid && enabled && (tok_addr == live_addr);
	end

endmodule : udc_addr_match

`default_nettype wire

// File: src/udc_ctrl_reg.sv
// Purpose: Control register of the high-speed USB device controller
// Assumes: Plain register port, read data one cycle after the strobe
// Notes: Bus reset and suspend levels come from the link core
// Function
// - Function address is zero after any reset
// - Address state off: default address only
// - Address state on: stored address only
// - Address state cleared by resets
// - Enable 0 disables, resets, stops transceiver
// - Enable 1 enables the controller
// - Detach 0 attaches through D+ pull-up
// - Detach 1 disconnects and suspends transceiver
// - Wake write 1 requests remote wake-up
// - Resume only after 5 ms suspend
// - Wake bit cleared when resume ends
//
// The plain strobed port was left to the implementer.
`default_nettype none

module udc_ctrl_reg
	import udc_pkg::*;
#(
	parameter int SUSPEND_CYC = SUSPEND_MIN_CYC,
	parameter int RESUME_LEN_CYC = RESUME_CYC
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register port
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Link state from the core
	input wire logic bus_reset,
	input wire logic bus_suspend,
	// Token address check
	input wire logic tok_valid,
	input wire logic [6:0] tok_addr,
	output logic tok_match,
	// Upstream resume and core reset
	output logic resume_drive,
	output logic core_rst,
	// Transceiver controls
	output udc_xcvr_t xcvr
);

	// Register select and write strobe
	logic sel;
	logic wr_hit;
	// Write data seen as the register image
	udc_ctrl_t wimg;
	// Stored fields
	logic [6:0] faddr_q;
	logic fa_en_q;
	logic en_q;
	logic en_d;
	logic detach_q;
	logic wake_q;
	logic pdd_q;
	// Resume sequencer
	udc_rs_t rs_q;
	logic sus_ok;
	logic res_done;
	logic res_end;
	// Current register image
	udc_ctrl_t img;

	// Decode the one mapped word
	assign sel = (reg_addr == CTRL_OFS);
	assign wr_hit = reg_wr && sel;
	assign wimg = udc_ctrl_t'(reg_wdata[CTRL_W-1:0]);

	// Enable as it will be after this cycle
	assign en_d = wr_hit ? wimg.controller_enable : en_q;

	// Controller enable
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			en_q <= CTRL_RESET.controller_enable;
		else if (wr_hit)
			en_q <= wimg.controller_enable;
	end

	// Function address; disable and bus reset return it to zero
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			faddr_q <= CTRL_RESET.function_address;
		else if (bus_reset || !en_d)
			faddr_q <= DEFAULT_ADDR;
		else if (wr_hit)
			faddr_q <= wimg.function_address;
	end

	// Address state; the hardware clear beats a firmware write
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			fa_en_q <= CTRL_RESET.address_state_enable;
		else if (bus_reset || !en_d)
			fa_en_q <= 1'b0;
		else if (wr_hit)
			fa_en_q <= wimg.address_state_enable;
	end

	// Detach command; kept across disable so attach stays under firmware
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			detach_q <= CTRL_RESET.detach;
		else if (wr_hit)
			detach_q <= wimg.detach;
	end

	// Pull-down disable, passed straight to the transceiver
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			pdd_q <= CTRL_RESET.pulldown_disable;
		else if (wr_hit)
			pdd_q <= wimg.pulldown_disable;
	end

	// Wake request: a write of one wins over the end-of-resume clear
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			wake_q <= CTRL_RESET.remote_wake_request;
		else if (!en_d)
			wake_q <= 1'b0;
		else if (wr_hit && wimg.remote_wake_request)
			wake_q <= 1'b1;
		else if (res_end)
			wake_q <= 1'b0;
	end

	// Times continuous suspend while idle and enabled
	udc_hold_timer #(
		.N(SUSPEND_CYC)
	) u_sus_tmr (
		.sys_clk(sys_clk),
		.rst(rst),
		.run(bus_suspend && en_q && (rs_q == RS_IDLE)),
		.done(sus_ok)
	);

	// Times the resume that we drive upstream
	udc_hold_timer #(
		.N(RESUME_LEN_CYC)
	) u_res_tmr (
		.sys_clk(sys_clk),
		.rst(rst),
		.run(rs_q == RS_DRIVE),
		.done(res_done)
	);

	// Last cycle of the resume
	assign res_end = (rs_q == RS_DRIVE) && res_done;

	// Resume sequencer; a detached device never starts a resume upstream
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			rs_q <= RS_IDLE;
		else if (!en_q)
			rs_q <= RS_IDLE;
		else
		begin
			case (rs_q)
				RS_IDLE:
					// Wait for a request and enough suspend
					if (wake_q && sus_ok && !detach_q)
						rs_q <= RS_DRIVE;
				RS_DRIVE:
					// Hold the K state for its full length
					if (res_done)
						rs_q <= RS_IDLE;
				default:
					rs_q <= RS_IDLE;
			endcase
		end
	end

	// Resume output straight from the state flop
	assign resume_drive = (rs_q == RS_DRIVE);

	// Address filter for incoming tokens
	udc_addr_match u_match (
		.sys_clk(sys_clk),
		.rst(rst),
		.enabled(en_q),
		.addr_state(fa_en_q),
		.func_addr(faddr_q),
		.tok_valid(tok_valid),
		.tok_addr(tok_addr),
		.tok_match(tok_match)
	);

	// Register image as software reads it
	always_comb
	begin
		img = CTRL_RESET;
		img.function_address = faddr_q;
		img.address_state_enable = fa_en_q;
		img.controller_enable = en_q;
		img.detach = detach_q;
		img.remote_wake_request = wake_q;
		img.pulldown_disable = pdd_q;
	end

	// Read data for one cycle; unmapped reads and idle cycles give zero
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			reg_rdata <= '0;
		else if (reg_rd && sel)
			reg_rdata <= {20'h00000, img};
		else
			reg_rdata <= '0;
	end

	// Core held in reset while the controller is disabled
	assign core_rst = !en_q;

	// Transceiver controls
	always_comb
	begin
		xcvr.xcvr_en = en_q;
		xcvr.pullup_en = en_q && !detach_q;
		xcvr.suspend_n = !detach_q;
		xcvr.pulldown_disable = pdd_q;
	end

	// Checks below watch only what this block drives
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// Helper: consecutive suspend cycles seen while enabled, saturating
	logic [TMR_W-1:0] sus_seen_q;
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			sus_seen_q <= '0;
		else if (!bus_suspend || !en_q)
			sus_seen_q <= '0;
		else if (sus_seen_q != {TMR_W{1'b1}})
			sus_seen_q <= sus_seen_q + TMR_W'(1);
	end

	// Helper: cycles of upstream resume seen so far, saturating
	logic [TMR_W-1:0] res_cnt_q;
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			res_cnt_q <= '0;
		else if (!resume_drive)
			res_cnt_q <= '0;
		else if (res_cnt_q != {TMR_W{1'b1}})
			res_cnt_q <= res_cnt_q + TMR_W'(1);
	end

	// Helper: read data seen as the register image, only the low field bits
	udc_ctrl_t rimg;
	assign rimg = udc_ctrl_t'(reg_rdata[CTRL_W-1:0]);

	// Last resume cycle followed by the first quiet one
	sequence s_res_end;
		resume_drive ##1 !resume_drive;
	endsequence

	a_reset_addr: assert property (bus_reset |=> faddr_q == DEFAULT_ADDR)
		else $error("function address not zero after bus reset");

	a_addr_state_clr: assert property (bus_reset |=> !fa_en_q && !img.address_state_enable)
		else $error("address state survived bus reset");

	a_default_addr: assert property (tok_valid && en_q && !fa_en_q
		&& tok_addr != DEFAULT_ADDR |=> !tok_match)
		else $error("non-default address accepted outside address state");

	a_stored_addr: assert property (tok_match |-> ($past(fa_en_q) ?
		$past(tok_addr) == $past(faddr_q) :
		$past(tok_addr) == DEFAULT_ADDR))
		else $error("token accepted for the wrong address");

	a_disable_all: assert property (wr_hit && !wimg.controller_enable |=> !en_q
		&& core_rst && !xcvr.xcvr_en && !xcvr.pullup_en && !wake_q)
		else $error("disable did not stop and reset the controller");

	a_enable_write: assert property (wr_hit && wimg.controller_enable
		|=> en_q && !core_rst && xcvr.xcvr_en)
		else $error("enable write not taken");

	a_attach_pull: assert property (wr_hit && wimg.controller_enable
		&& !wimg.detach |=> xcvr.pullup_en && xcvr.suspend_n)
		else $error("attach did not raise the pull-up");

	a_detach_susp: assert property (detach_q |-> !xcvr.suspend_n && !xcvr.pullup_en)
		else $error("detached but transceiver not suspended");

	a_wake_set: assert property (wr_hit && wimg.controller_enable
		&& wimg.remote_wake_request |=> wake_q)
		else $error("wake request write not taken");

	a_wake_zero: assert property (!wake_q && !(wr_hit && wimg.remote_wake_request)
		|=> !wake_q)
		else $error("wake request rose without a write of one");

	a_resume_gap: assert property ($rose(resume_drive)
		|-> $past(sus_seen_q) >= TMR_W'(SUSPEND_CYC))
		else $error("resume started before the suspend time");

	a_wake_end: assert property (s_res_end |-> !wake_q || $past(wr_hit))
		else $error("wake bit not cleared at end of resume");

	a_pulldown_out: assert property (wr_hit
		|=> xcvr.pulldown_disable == $past(wimg.pulldown_disable))
		else $error("pull-down disable not routed");

	a_disabled_idle: assert property (!en_q
		|-> faddr_q == DEFAULT_ADDR && !fa_en_q && !wake_q)
		else $error("disabled controller kept address or wake state");

	a_state_read: assert property (reg_rd && sel
		|=> rimg.address_state_enable == $past(fa_en_q))
		else $error("address state bit read back wrong");

	a_enable_read: assert property (reg_rd && sel
		|=> rimg.controller_enable == $past(xcvr.xcvr_en))
		else $error("controller enable bit read back wrong");

	a_detach_read: assert property (reg_rd && sel
		|=> rimg.detach == !$past(xcvr.suspend_n))
		else $error("detach bit read back wrong");

	a_resume_len: assert property ($fell(resume_drive) && $past(en_q)
		|-> res_cnt_q == TMR_W'(RESUME_LEN_CYC + 1))
		else $error("upstream resume ended at the wrong length");

	a_resume_cap: assert property (resume_drive
		|-> res_cnt_q <= TMR_W'(RESUME_LEN_CYC))
		else $error("upstream resume ran too long");

endmodule : udc_ctrl_reg

`default_nettype wire

// File: verif/udc_host_model.sv
// Purpose: Behavioural USB host seen through the link core
// Assumes: Bench calls the tasks; all changes follow a rising edge
// Notes: Idle token address is inverted so a stale value cannot match
`default_nettype none

module udc_host_model
	import udc_pkg::*;
(
	// Clock
	input wire logic sys_clk,
	// Link state towards the block
	output logic bus_reset,
	output logic bus_suspend,
	// Token towards the block
	output logic tok_valid,
	output logic [6:0] tok_addr
);
	timeunit 1ns;
	timeprecision 1ps;

	// Quiet bus at time zero
	initial
	begin
		bus_reset = 1'b0;
		bus_suspend = 1'b0;
		tok_valid = 1'b0;
		tok_addr = 7'h7f;
	end

	// One token for one cycle
	task automatic send_token(input logic [6:0] a);
		@(posedge sys_clk);
		tok_valid <= 1'b1;
		tok_addr <= a;
		@(posedge sys_clk);
		tok_valid <= 1'b0;
		tok_addr <= ~a;
	endtask : send_token

	// One cycle of bus reset is enough for the link core
	task automatic pulse_reset();
		@(posedge sys_clk);
		bus_reset <= 1'b1;
		@(posedge sys_clk);
		bus_reset <= 1'b0;
	endtask : pulse_reset

	// Suspend level of the bus
	task automatic set_suspend(input logic s);
		@(posedge sys_clk);
		bus_suspend <= s;
	endtask : set_suspend

endmodule : udc_host_model

`default_nettype wire

// File: verif/usb_device_control_register_test.sv
// Purpose: Self-checking bench of the USB device control register
// Assumes: Short suspend and resume counts set by parameter
// Notes: Firmware role is played here, the host by a model
`default_nettype none

module usb_device_control_register_test
	import udc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// Short counts keep the run brief
	localparam int SUS = 20;
	localparam int RES = 8;
	localparam logic [31:0] A = CTRL_OFS;

	// Clock, reset and register port
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [31:0] reg_addr = 32'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	// Host side and outputs
	logic bus_reset, bus_suspend, tok_valid, tok_match, resume_drive, core_rst;
	logic [6:0] tok_addr;
	udc_xcvr_t xcvr;
	// Counters
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;

	// 20 MHz clock
	always #25 sys_clk = ~sys_clk;

	udc_ctrl_reg #(.SUSPEND_CYC(SUS), .RESUME_LEN_CYC(RES)) uut (
		.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_reset(bus_reset),
		.bus_suspend(bus_suspend), .tok_valid(tok_valid), .tok_addr(tok_addr),
		.tok_match(tok_match), .resume_drive(resume_drive), .core_rst(core_rst), .xcvr(xcvr));

	udc_host_model host (
		.sys_clk(sys_clk), .bus_reset(bus_reset), .bus_suspend(bus_suspend),
		.tok_valid(tok_valid), .tok_addr(tok_addr));

	// Pin image: pull-down, suspend_n, pull-up, transceiver, core reset
	function automatic logic [31:0] pins();
		return {27'h0, xcvr.pulldown_disable, xcvr.suspend_n, xcvr.pullup_en,
			xcvr.xcvr_en, core_rst};
	endfunction : pins

	// Single compare, case equality so unknowns fail
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	// Register write, one strobe cycle
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	// Register read, data judged in the following cycle only
	task automatic rd(input logic [31:0] a, input logic [31:0] e, input string m);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e, m);
	endtask : rd

	// Token then its registered answer
	task automatic tok(input logic [6:0] a, input logic e);
		host.send_token(a);
		#1;
		chk({31'h0, tok_match}, {31'h0, e}, "token match");
	endtask : tok

	task automatic t_reset();
		rd(A, 32'h200, "reset image");
		chk(pins(), 32'h01, "reset pins");
		rd(A + 32'h4, 32'h0, "unmapped read");
		$display("reset test done");
	endtask : t_reset

	task automatic t_enable();
		wr(A, 32'h100);
		chk(pins(), 32'h0e, "attached pins");
		rd(A, 32'h100, "enabled image");
		wr(A, 32'h300);
		chk(pins(), 32'h02, "detached pins");
		rd(A, 32'h300, "detached image");
		wr(A, 32'h900);
		chk(pins(), 32'h1e, "pull-down pin");
		rd(A, 32'h900, "pull-down image");
		$display("enable test done");
	endtask : t_enable

	task automatic t_addr();
		wr(A, 32'h100);
		tok(7'h00, 1'b1);
		tok(7'h05, 1'b0);
		wr(A, 32'h185);
		rd(A, 32'h185, "address image");
		tok(7'h05, 1'b1);
		tok(7'h00, 1'b0);
		wr(A + 32'h10, 32'h100);
		rd(A, 32'h185, "unmapped write ignored");
		host.pulse_reset();
		rd(A, 32'h100, "after bus reset");
		tok(7'h05, 1'b0);
		$display("address test done");
	endtask : t_addr

	task automatic t_disable();
		wr(A, 32'h185);
		wr(A, 32'h000);
		chk(pins(), 32'h09, "disabled pins");
		rd(A, 32'h000, "disabled image");
		tok(7'h00, 1'b0);
		$display("disable test done");
	endtask : t_disable

	task automatic t_wake();
		int n;
		wr(A, 32'h500);
		wr(A, 32'h100);
		rd(A, 32'h500, "wake write 0 ignored");
		host.set_suspend(1'b1);
		repeat (10) @(posedge sys_clk);
		host.set_suspend(1'b0);
		#1;
		chk({31'h0, resume_drive}, 32'h0, "short suspend");
		host.set_suspend(1'b1);
		n = 0;
		while (resume_drive !== 1'b1 && n < 100)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk(n, SUS + 1, "suspend wait");
		n = 0;
		while (resume_drive === 1'b1 && n < 100)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk(n, RES + 1, "resume length");
		host.set_suspend(1'b0);
		rd(A, 32'h100, "wake bit cleared");
		$display("wake test done");
	endtask : t_wake

	// Verdict and end of run
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	// Hang guard, far above the hundred or so cycles needed
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_errors++;
			$display("[FAIL] %0t timeout", $time);
			tally_and_finish();
		end
	end

	// Main sequence
	initial
	begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_enable();
		t_addr();
		t_disable();
		t_wake();
		tally_and_finish();
	end

endmodule : usb_device_control_register_test

`default_nettype wire
